// *** common/rpc_pkg.sv ***
// Constants, register map and helper tables of the ramp and protection control block
`default_nettype none
package rpc_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_RAMP_CFG = 8'h03;
	localparam logic [7:0] ADDR_CUR_LIMIT = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h16;

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int RISE_LSB = 4;
	localparam int SHAPE_BIT = 3;
	localparam int FALL_LSB = 0;
	localparam int DROOP_LSB = 5;
	localparam int COMP_BIT = 4;
	localparam int LIMIT_LSB = 0;
	localparam logic [7:0] RAMP_CFG_RST = 8'h1C;
	localparam logic [7:0] CUR_LIMIT_RST = 8'h1B;
	localparam logic [3:0] LIMIT_MAX = 4'hB;
	// Status flags, active low, 1 means no event
	localparam int FL_WARN = 0;
	localparam int FL_WIN = 1;
	localparam int FL_OC = 2;
	localparam int FL_UV = 3;
	localparam int FL_OT = 4;
	localparam int FL_TR = 5;
	localparam logic [5:0] STATUS_RST = 6'h3F;

	// ------------------------------------------------------------
	// Thresholds and timing
	// ------------------------------------------------------------
	localparam logic [7:0] WARN_SET_C = 8'd120;
	localparam logic [7:0] WARN_CLR_C = 8'd117;
	localparam logic [7:0] FAULT_C = 8'd130;
	localparam int LSB_UV = 2500;
	localparam int TRACK_MV = 250;
	localparam logic [11:0] TRACK_LSB = 12'(TRACK_MV * 1000 / LSB_UV);
	localparam int STEP_MV = 10;
	localparam logic [11:0] STEP_LSB = 12'(STEP_MV * 1000 / LSB_UV);
	localparam int CLK_PERIOD_NS = 8;
	localparam int MS_NS = 1000000;
	localparam logic [7:0] RETRY_MS = 8'd130;
	localparam logic [7:0] PG_DELAY_MAX_MS = 8'd150;
	localparam int MCLK_PERIOD_NS = 1000;

	typedef enum logic [2:0] {ST_OFF, ST_RISE, ST_STEADY, ST_FALL, ST_HOLD} rpc_state_t;

	// Master clock periods per 10 mV step for each slew code
	function automatic logic [7:0] rpc_step_ticks(input logic [2:0] code);
		logic [15:0] ns;
		unique case (code)
			3'h0: ns = 16'd200;
			3'h1: ns = 16'd100;
			3'h2: ns = 16'd50;
			3'h3: ns = 16'd40;
			3'h4: ns = 16'd20;
			3'h5: ns = 16'd10;
			3'h6: ns = 16'd5;
			3'h7: ns = 16'd200;
		endcase
		return 8'(32'(ns) * 1000 / MCLK_PERIOD_NS);
	endfunction

	// Current limit in percent of rating; codes above the top clamp to it
	function automatic logic [7:0] rpc_limit_pct(input logic [3:0] code);
		logic [7:0] pct;
		pct = 8'd140;
		if (code < LIMIT_MAX) begin
			pct = 8'(8'd37 + 8'(code) * 8'd10);
		end
		return pct;
	endfunction

endpackage
`default_nettype wire

// *** verilog/rpc_step_timer.sv ***
// Divider that turns master clock ticks into reference step pulses
`timescale 1ns/1ns
`default_nettype none
module rpc_step_timer
	import rpc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Control
	input wire logic tick,
	input wire logic run,
	input wire logic [2:0] code,
	// Step pulse
	output logic step
);

	logic [7:0] cnt_reg;

	// ------------------------------------------------------------
	// Count master ticks, one step per programmed interval
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_reg <= 8'h00;
			step <= 1'b0;
		end else if (!run) begin
			cnt_reg <= 8'h00;
			step <= 1'b0;
		end else begin
			step <= 1'b0;
			if (tick) begin
				if (cnt_reg >= rpc_step_ticks(code) - 8'h01) begin
					cnt_reg <= 8'h00;
					step <= 1'b1;
				end else begin
					cnt_reg <= cnt_reg + 8'h01;
				end
			end
		end
	end

endmodule
`default_nettype wire

// *** verilog/rpc_ramp_protect_ctrl.sv ***
// Ramp generation, current limit setting and protection state of the converter
//
// Operation
// - Rise and fall slew codes, defaults 1/4
// - Bit 3 enables shaped turn-off ramp
// - Bits 7:5 select load-regulation droop
// - Bit 4 enables limit temperature compensation
// - Limit code, reset 0xB, clamp above
// - Warnings report only, never turn off
// - Thermal warning above 120, clears below 117
// - Power-good low outside programmable window
// - Power-good checked in steady state, delayed
// - Warning pulls pin low, flag zero
// - External low on pin starts warning
// - Power-good low at command or ramp
// - Any fault turns the output off
// - Overcurrent past pre-bias: flag, fast off
// - Steady undervoltage without overcurrent: sequenced off
// - Above 130 degrees: flag, sequenced off
// - Non-latching thermal fault restarts below 120
// - Rising tracking error over 250mV: fast off
// - Tracking protection can be disabled
// - Switching withheld until reference passes pre-bias
// - Window and undervoltage thresholds scale with the active setpoint
// - Ramp in 10mV steps from master clock
// - Non-latching faults retry every 130ms
`timescale 1ns/1ns
`default_nettype none
module rpc_ramp_protect_ctrl
	import rpc_pkg::*;
#(
	parameter int MS_CYCLES = MS_NS / CLK_PERIOD_NS
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	output logic [7:0] reg_rdata,
	// Control levels
	input wire logic turn_on,
	input wire logic track_en,
	input wire logic pg_hi_110,
	input wire logic pg_lo_95,
	input wire logic [7:0] pg_delay_ms,
	input wire logic pg_off_immediate,
	input wire logic [6:0] uv_pct,
	input wire logic [3:0] latch_mask,
	// Measurements
	input wire logic [11:0] vout_meas,
	input wire logic [11:0] vset,
	input wire logic [7:0] iout_pct,
	input wire logic [7:0] temp_c,
	// Pins
	input wire logic mclk_pin,
	input wire logic pg_in,
	output logic pg_out,
	output logic pg_oe_n,
	// Power stage and settings
	output logic [11:0] ref_code,
	output logic hs_on,
	output logic ls_on,
	output logic [2:0] droop_code,
	output logic copper_comp_enable,
	output logic [3:0] limit_threshold_code
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	rpc_state_t state_reg;
	logic [7:0] ramp_rate_config;
	logic [5:0] st_reg;
	logic [16:0] ms_cnt_reg;
	logic ms_tick;
	logic mclk_s1, mclk_s2, mclk_s3;
	logic pg_s1, pg_s2;
	logic [1:0] rel_cnt_reg;
	logic [7:0] hold_cnt_reg;
	logic [7:0] pg_cnt_reg;
	logic [11:0] prebias_reg;
	logic prebias_ok;
	logic step;
	logic [18:0] vo100, win_hi, win_lo, uv_lvl;
	logic [11:0] trk_diff;
	logic in_window, ext_low, pg_ready, pg_good;
	logic oc_hit, trk_hit, uv_hit, ot_hit, fast_trip, seq_trip;
	logic st_write;
	logic [3:0] flt_ev, flt_gone;

	// ------------------------------------------------------------
	// Synchronisers and millisecond tick
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mclk_s1 <= 1'b0;
			mclk_s2 <= 1'b0;
			mclk_s3 <= 1'b0;
			pg_s1 <= 1'b0;
			pg_s2 <= 1'b0;
		end else begin
			mclk_s1 <= mclk_pin;
			mclk_s2 <= mclk_s1;
			mclk_s3 <= mclk_s2;
			pg_s1 <= pg_in;
			pg_s2 <= pg_s1;
		end
	end

	// Free running millisecond divider
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ms_cnt_reg <= 17'h00000;
			ms_tick <= 1'b0;
		end else if (ms_cnt_reg >= 17'(MS_CYCLES - 1)) begin
			ms_cnt_reg <= 17'h00000;
			ms_tick <= 1'b1;
		end else begin
			ms_cnt_reg <= ms_cnt_reg + 17'h00001;
			ms_tick <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	assign st_write = reg_wr && reg_addr == ADDR_STATUS;

	// Configuration writes, limit code clamped on entry
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ramp_rate_config <= RAMP_CFG_RST;
			droop_code <= CUR_LIMIT_RST[DROOP_LSB +: 3];
			copper_comp_enable <= CUR_LIMIT_RST[COMP_BIT];
			limit_threshold_code <= CUR_LIMIT_RST[LIMIT_LSB +: 4];
		end else if (reg_wr) begin
			if (reg_addr == ADDR_RAMP_CFG) begin
				ramp_rate_config <= {1'b0, reg_wdata[6:0]};
			end
			if (reg_addr == ADDR_CUR_LIMIT) begin
				droop_code <= reg_wdata[DROOP_LSB +: 3];
				copper_comp_enable <= reg_wdata[COMP_BIT];
				limit_threshold_code <= (reg_wdata[3:0] > LIMIT_MAX) ? LIMIT_MAX : reg_wdata[3:0];
			end
		end
	end

	// Registered read data, unmapped offsets read zero
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= 8'h00;
		end else begin
			case (reg_addr)
				ADDR_RAMP_CFG: reg_rdata <= ramp_rate_config;
				ADDR_CUR_LIMIT: reg_rdata <= {droop_code, copper_comp_enable, limit_threshold_code};
				ADDR_STATUS: reg_rdata <= {2'b00, st_reg};
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Threshold comparisons, window and undervoltage scaled by the active setpoint
	// ------------------------------------------------------------
	assign vo100 = 19'(vout_meas * 7'd100);
	assign win_hi = 19'(vset * (pg_hi_110 ? 7'd110 : 7'd105));
	assign win_lo = 19'(vset * (pg_lo_95 ? 7'd95 : 7'd90));
	assign uv_lvl = 19'(vset * uv_pct);
	assign in_window = vo100 <= win_hi && vo100 >= win_lo;
	assign trk_diff = (vout_meas > ref_code) ? vout_meas - ref_code : ref_code - vout_meas;
	assign oc_hit = prebias_ok && (hs_on || ls_on) && iout_pct >= rpc_limit_pct(limit_threshold_code);
	assign trk_hit = track_en && state_reg == ST_RISE && prebias_ok && trk_diff > TRACK_LSB;
	assign uv_hit = state_reg == ST_STEADY && vo100 < uv_lvl && !oc_hit;
	assign ot_hit = temp_c > FAULT_C;
	assign fast_trip = oc_hit || trk_hit;
	assign seq_trip = uv_hit || ot_hit;

	// ------------------------------------------------------------
	// Ramp step timing from the master clock
	// ------------------------------------------------------------
	rpc_step_timer u_step (
		.clk(clk),
		.arst_n(arst_n),
		.tick(mclk_s2 && !mclk_s3),
		.run(state_reg == ST_RISE || state_reg == ST_FALL),
		.code(state_reg == ST_FALL ? ramp_rate_config[FALL_LSB +: 3] : ramp_rate_config[RISE_LSB +: 3]),
		.step(step)
	);

	// ------------------------------------------------------------
	// Sequencing state machine
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= ST_OFF;
			ref_code <= 12'h000;
			prebias_reg <= 12'h000;
			prebias_ok <= 1'b0;
			hs_on <= 1'b0;
			ls_on <= 1'b0;
			hold_cnt_reg <= 8'h00;
		end else begin
			unique case (state_reg)
				ST_OFF: begin
					ref_code <= 12'h000;
					prebias_ok <= 1'b0;
					if (turn_on && &st_reg[FL_TR:FL_OC] && !ot_hit) begin
						prebias_reg <= vout_meas;
						state_reg <= ST_RISE;
					end
				end
				ST_RISE: begin
					if (fast_trip) begin
						hs_on <= 1'b0;
						ls_on <= 1'b0;
						hold_cnt_reg <= 8'h00;
						state_reg <= ST_HOLD;
					end else if (ot_hit || !turn_on) begin
						state_reg <= ST_FALL;
					end else begin
						if (step) begin
							ref_code <= (vset - ref_code > STEP_LSB) ? ref_code + STEP_LSB : vset;
						end
						if (ref_code >= prebias_reg) begin
							prebias_ok <= 1'b1;
							hs_on <= 1'b1;
							ls_on <= 1'b1;
						end
						if (prebias_ok && ref_code >= vset) begin
							state_reg <= ST_STEADY;
						end
					end
				end
				ST_STEADY: begin
					ref_code <= vset;
					if (oc_hit) begin
						hs_on <= 1'b0;
						ls_on <= 1'b0;
						hold_cnt_reg <= 8'h00;
						state_reg <= ST_HOLD;
					end else if (seq_trip || !turn_on) begin
						state_reg <= ST_FALL;
					end
				end
				ST_FALL: begin
					if (oc_hit || !ramp_rate_config[SHAPE_BIT] || ref_code == 12'h000) begin
						hs_on <= 1'b0;
						ls_on <= 1'b0;
						hold_cnt_reg <= 8'h00;
						state_reg <= ST_HOLD;
					end else if (step) begin
						ref_code <= (ref_code > STEP_LSB) ? ref_code - STEP_LSB : 12'h000;
					end
				end
				ST_HOLD: begin
					ref_code <= 12'h000;
					if (ms_tick) begin
						hold_cnt_reg <= hold_cnt_reg + 8'h01;
					end
					if (hold_cnt_reg >= RETRY_MS) begin
						state_reg <= ST_OFF;
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Fault flags: event wins, restore when gone and allowed
	// ------------------------------------------------------------
	assign flt_ev = {trk_hit, ot_hit, uv_hit, oc_hit};
	// Overcurrent counts as gone only once the measured current is back under the limit
	assign flt_gone = {!trk_hit, temp_c < WARN_SET_C, !uv_hit, iout_pct < rpc_limit_pct(limit_threshold_code)};

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg[FL_TR:FL_OC] <= STATUS_RST[FL_TR:FL_OC];
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (flt_ev[i]) begin
					st_reg[FL_OC + i] <= 1'b0;
				end else if (flt_gone[i] && (!latch_mask[i] || !turn_on || (st_write && reg_wdata[FL_OC + i]))) begin
					st_reg[FL_OC + i] <= 1'b1;
				end
			end
		end
	end

	// Thermal warning with hysteresis, report only
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg[FL_WARN] <= STATUS_RST[FL_WARN];
		end else if (temp_c > WARN_SET_C) begin
			st_reg[FL_WARN] <= 1'b0;
		end else if (temp_c < WARN_CLR_C) begin
			st_reg[FL_WARN] <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Power-good delay, window flag and open-drain pin
	// ------------------------------------------------------------
	assign ext_low = !pg_s2 && rel_cnt_reg == 2'h3;
	assign pg_ready = state_reg == ST_STEADY && (pg_cnt_reg >= pg_delay_ms || pg_cnt_reg >= PG_DELAY_MAX_MS);
	// External low is only reported, so our own pull never masks it and the flag stays steady
	assign pg_good = pg_ready && in_window && (turn_on || !pg_off_immediate);

	// Release delay counted from steady state entry
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pg_cnt_reg <= 8'h00;
		end else if (state_reg != ST_STEADY) begin
			pg_cnt_reg <= 8'h00;
		end else if (ms_tick && pg_cnt_reg < PG_DELAY_MAX_MS) begin
			pg_cnt_reg <= pg_cnt_reg + 8'h01;
		end
	end

	// Pin drive; own low is ignored until the line has settled released
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pg_out <= 1'b0;
			pg_oe_n <= 1'b0;
			rel_cnt_reg <= 2'h0;
		end else begin
			pg_out <= 1'b0;
			pg_oe_n <= pg_good;
			if (!pg_oe_n) begin
				rel_cnt_reg <= 2'h0;
			end else if (rel_cnt_reg != 2'h3) begin
				rel_cnt_reg <= rel_cnt_reg + 2'h1;
			end
		end
	end

	// Window flag reports only while the check is live
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg[FL_WIN] <= STATUS_RST[FL_WIN];
		end else if (pg_ready && (!in_window || ext_low)) begin
			st_reg[FL_WIN] <= 1'b0;
		end else begin
			st_reg[FL_WIN] <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	sequence s_trip;
		fast_trip && (state_reg == ST_RISE || state_reg == ST_STEADY);
	endsequence
	sequence s_hold_entry;
		state_reg != ST_HOLD ##1 state_reg == ST_HOLD;
	endsequence

	chk_fast_off: assert property (s_trip |=> !hs_on && !ls_on && state_reg == ST_HOLD)
		else $error("switches not off after fast trip");
	chk_oc_flag: assert property (oc_hit |=> !st_reg[FL_OC])
		else $error("overcurrent flag not low");
	chk_track_off: assert property (!track_en && st_reg[FL_TR] |=> st_reg[FL_TR])
		else $error("tracking flag fell while disabled");
	chk_warn_set: assert property (temp_c > WARN_SET_C |=> !st_reg[FL_WARN])
		else $error("thermal warning not raised");
	chk_warn_hyst: assert property (!st_reg[FL_WARN] && temp_c >= WARN_CLR_C |=> !st_reg[FL_WARN])
		else $error("thermal warning left early");
	chk_ot_ramp: assert property (state_reg == ST_STEADY && ot_hit && !oc_hit |=> state_reg == ST_FALL)
		else $error("no sequenced turn-off on thermal fault");
	chk_limit_clamp: assert property (reg_wr && reg_addr == ADDR_CUR_LIMIT && reg_wdata[3:0] > LIMIT_MAX
		|=> limit_threshold_code == LIMIT_MAX)
		else $error("limit code not clamped");
	chk_pg_off: assert property (state_reg == ST_OFF ##1 state_reg == ST_OFF |-> !pg_oe_n)
		else $error("power-good released while off");
	chk_retry_wait: assert property (s_hold_entry |-> (state_reg == ST_HOLD)[*8])
		else $error("retry wait cut short");
	chk_prebias: assert property (state_reg == ST_RISE && !prebias_ok && $past(state_reg) == ST_OFF |-> !hs_on)
		else $error("switching before pre-bias passed");

endmodule
`default_nettype wire

// *** tb/rpc_load_model.sv ***
// Far-side model: manager master clock and the output voltage seen by the sense path
`timescale 1ns/1ns
`default_nettype none
module rpc_load_model
	import rpc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// From the controller
	input wire logic [11:0] ref_code,
	input wire logic hs_on,
	input wire logic ls_on,
	// Bench controls
	input wire logic [11:0] prebias,
	input wire logic [11:0] offset,
	// To the controller
	output logic mclk_pin,
	output logic [11:0] vout_meas
);
	// Master clock runs free, as the manager keeps it going
	initial begin
		mclk_pin = 1'b0;
		forever #(MCLK_PERIOD_NS / 2) mclk_pin = ~mclk_pin;
	end
	// Output follows the reference while switching, else rests at the pre-bias level
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			vout_meas <= 12'h000;
		end else if (hs_on && ls_on) begin
			vout_meas <= ref_code + offset;
		end else begin
			vout_meas <= prebias + offset;
		end
	end
endmodule
`default_nettype wire

// *** tb/rpc_ramp_protect_ctrl_tb.sv ***
// Self-checking bench of the ramp and protection controller
`timescale 1ns/1ns
`default_nettype none
module rpc_ramp_protect_ctrl_tb import rpc_pkg::*;;
	localparam logic [11:0] VSET = 12'h028;
	logic clk, arst_n, reg_wr, turn_on, track_en, pg_off_immediate, pg_in, pg_out, pg_oe_n;
	logic hs_on, ls_on, copper_comp_enable, mclk_pin, ext_low;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, pg_delay_ms, iout_pct, temp_c, r, d;
	logic [11:0] vout_meas, ref_code, prebias, offset;
	logic [2:0] droop_code;
	logic [3:0] limit_threshold_code, latch_mask;
	logic [15:0] seed;
	int miscompares, num_checks, n, i;

	// PG wire with pull-up: low when the controller or the bench pulls it
	assign pg_in = pg_oe_n & ~ext_low;

	rpc_ramp_protect_ctrl #(.MS_CYCLES(10)) DUT (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata), .turn_on(turn_on),
		.track_en(track_en), .pg_hi_110(1'b0), .pg_lo_95(1'b1), .pg_delay_ms(pg_delay_ms),
		.pg_off_immediate(pg_off_immediate), .uv_pct(7'h50), .latch_mask(latch_mask),
		.vout_meas(vout_meas), .vset(VSET), .iout_pct(iout_pct), .temp_c(temp_c), .mclk_pin(mclk_pin),
		.pg_in(pg_in), .pg_out(pg_out), .pg_oe_n(pg_oe_n), .ref_code(ref_code), .hs_on(hs_on),
		.ls_on(ls_on), .droop_code(droop_code), .copper_comp_enable(copper_comp_enable),
		.limit_threshold_code(limit_threshold_code));
	rpc_load_model load (.clk(clk), .arst_n(arst_n), .ref_code(ref_code), .hs_on(hs_on), .ls_on(ls_on),
		.prebias(prebias), .offset(offset), .mclk_pin(mclk_pin), .vout_meas(vout_meas));

	// ------------------------------------------------------------
	// Bench tasks and expectations
	// ------------------------------------------------------------
	function automatic logic [15:0] xs(input logic [15:0] s);
		logic [15:0] t;
		t = s ^ (s << 7);
		t = t ^ (t >> 9);
		return t ^ (t << 8);
	endfunction
	function automatic logic [3:0] exp_limit(input logic [3:0] c);
		return (c > LIMIT_MAX) ? LIMIT_MAX : c;
	endfunction
	task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic cyc(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		reg_addr <= a;
		cyc(2);
		v = reg_rdata;
	endtask
	task automatic st(input int b, input logic v);
		rd(ADDR_STATUS, r);
		chk("status flag", v, r[b]);
	endtask
	task automatic wait_hs(input logic v, output int k);
		for (k = 0; k < 12000 && hs_on !== v; k++) begin
			cyc(1);
		end
		chk("switch wait", 1'b1, k < 12000);
	endtask
	// Follows a rise to the setpoint, watching step size and switch hold-off
	task automatic wait_ref(output int k);
		logic early, bad;
		logic [11:0] last;
		early = 1'b0;
		bad = 1'b0;
		last = ref_code;
		for (k = 0; k < 10000 && ref_code !== VSET; k++) begin
			cyc(1);
			if (hs_on === 1'b1 && ref_code < prebias) early = 1'b1;
			if (ref_code !== last && ref_code !== last + 12'h004) bad = 1'b1;
			last = ref_code;
		end
		chk("switching under pre-bias", 1'b0, early);
		chk("reference step", 1'b0, bad);
		chk("setpoint reached", VSET, ref_code);
	endtask
	task automatic stop_test();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Watchdog well beyond the expected run length
	initial begin
		#(90000 * 8);
		miscompares++;
		stop_test();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{arst_n, reg_wr, turn_on, pg_off_immediate, ext_low} = '0;
		track_en = 1'b1;
		latch_mask = 4'h0;
		{reg_addr, reg_wdata} = '0;
		pg_delay_ms = 8'h02;
		iout_pct = 8'h32;
		temp_c = 8'h32;
		prebias = 12'h014;
		offset = 12'h000;
		seed = 16'd56554;
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		cyc(1);
		chk("reset limit", 4'hB, limit_threshold_code);
		chk("reset droop", 3'h0, droop_code);
		chk("reset comp", 1'b1, copper_comp_enable);
		rd(ADDR_RAMP_CFG, r);
		chk("reset ramp reg", 8'h1C, r);
		rd(ADDR_STATUS, r);
		chk("reset status", 8'h3F, r);
		for (i = 0; i < 10; i++) begin
			seed = xs(seed);
			d = (i == 0) ? 8'hFF : (i == 1) ? 8'h0C : seed[7:0];
			wr(ADDR_CUR_LIMIT, d);
			chk("limit code", exp_limit(d[3:0]), limit_threshold_code);
			chk("droop code", d[7:5], droop_code);
			chk("comp enable", d[4], copper_comp_enable);
			rd(ADDR_CUR_LIMIT, r);
			chk("limit reg", {d[7:4], exp_limit(d[3:0])}, r);
			wr(ADDR_RAMP_CFG, seed[15:8]);
			wr(8'h40, 8'hFF);
			rd(ADDR_RAMP_CFG, r);
			chk("ramp reg", {1'b0, seed[14:8]}, r);
		end
		wr(ADDR_CUR_LIMIT, 8'h1B);
		wr(ADDR_RAMP_CFG, 8'h6E);
		// Rise into pre-bias, then power-good release delay
		@(posedge clk) turn_on <= 1'b1;
		wait_ref(n);
		chk("ramp time", 1'b1, n > 5500 && n < 7000);
		cyc(10);
		chk("pg held", 1'b0, pg_oe_n);
		cyc(30);
		chk("pg released", 1'b1, pg_oe_n);
		// Thermal warning hysteresis, output kept on
		@(posedge clk) temp_c <= 8'h79;
		st(FL_WARN, 1'b0);
		@(posedge clk) temp_c <= 8'h76;
		st(FL_WARN, 1'b0);
		@(posedge clk) temp_c <= 8'h74;
		st(FL_WARN, 1'b1);
		chk("on after warning", 1'b1, hs_on);
		// Window excursion, then external pull-down
		@(posedge clk) offset <= 12'h008;
		cyc(5);
		chk("pg out of window", 1'b0, pg_oe_n);
		st(FL_WIN, 1'b0);
		@(posedge clk) offset <= 12'h000;
		cyc(5);
		chk("pg back in window", 1'b1, pg_oe_n);
		st(FL_WIN, 1'b1);
		@(posedge clk) ext_low <= 1'b1;
		cyc(3);
		st(FL_WIN, 1'b0);
		chk("pg not driven by us", 1'b1, pg_oe_n);
		@(posedge clk) ext_low <= 1'b0;
		// Overcurrent: fast off, flag while present, retry after hold
		@(posedge clk) iout_pct <= 8'h96;
		cyc(3);
		chk("oc switches", 2'b00, {hs_on, ls_on});
		st(FL_OC, 1'b0);
		@(posedge clk) iout_pct <= 8'h32;
		wait_hs(1'b1, n);
		chk("retry gap", 1'b1, n > 1280 && n < 4700);
		st(FL_OC, 1'b1);
		wait_ref(n);
		// Undervoltage in steady state: sequenced ramp-down
		@(posedge clk) offset <= 12'hFF4;
		st(FL_UV, 1'b0);
		chk("pg at ramp-down", 1'b0, pg_oe_n);
		@(posedge clk) offset <= 12'h000;
		cyc(700);
		chk("uv ramping down", 1'b1, hs_on === 1'b1 && ref_code < VSET);
		wait_hs(1'b0, n);
		// Tracking error while rising (latching), host restore, then with tracking disabled
		@(posedge clk) latch_mask <= 4'h8;
		wait_hs(1'b1, n);
		@(posedge clk) offset <= 12'h06E;
		cyc(3);
		chk("tracking switches", 2'b00, {hs_on, ls_on});
		st(FL_TR, 1'b0);
		@(posedge clk) track_en <= 1'b0;
		wr(ADDR_STATUS, 8'h20);
		st(FL_TR, 1'b1);
		@(posedge clk) offset <= 12'h000;
		wait_hs(1'b1, n);
		@(posedge clk) offset <= 12'h06E;
		cyc(20);
		chk("tracking disabled", 1'b1, hs_on);
		st(FL_TR, 1'b1);
		@(posedge clk) offset <= 12'h000;
		// Overtemperature: off, no restart until below the warning level
		@(posedge clk) temp_c <= 8'h83;
		st(FL_OT, 1'b0);
		wait_hs(1'b0, n);
		@(posedge clk) temp_c <= 8'h7D;
		cyc(3000);
		chk("warm restart held", 1'b0, hs_on);
		@(posedge clk) temp_c <= 8'h6E;
		wait_hs(1'b1, n);
		chk("cool restart", 1'b1, hs_on);
		wait_ref(n);
		cyc(40);
		// Power-good dropped at the command itself
		@(posedge clk) pg_off_immediate <= 1'b1;
		@(posedge clk) turn_on <= 1'b0;
		cyc(2);
		chk("pg at command", 1'b0, pg_oe_n);
		chk("pg level", 1'b0, pg_out);
		stop_test();
	end
endmodule
`default_nettype wire
